//--- verilog/dmrb_bank.v
// Drive monitor readout bank: live monitor items, sent as ASCII hex
// ----------------------------------------
// How it works
// (R01) Torque current item: signed, 10000 means 100 percent rated current.
// (R02) Output frequency item: 100 counts per 1.00 Hz, unsigned magnitude.
// (R03) Frequency reply prefixed by space or minus, five bytes long.
// (R04) Motor power item: signed, 10000 means 100 percent rated output.
// (R05) Output current item: 100 counts per 1 percent of rated current.
// (R06) Run command: clear bit 15, inputs bits 2-6, reverse 1, forward 0.
// (R07) Run command merges link commands with physical terminal states.
// (R08) Flags: bit 15 writing, bit 12 link valid, bit 11 trip.
// (R09) Flags: bit 10 decelerating, bit 9 accelerating.
// (R10) Flags: bit 7 voltage, 6 torque limit, 5 bus up, 4 braking.
// (R11) Flags: bit 3 output off, bit 2 DC braking, bit 0 forward.
// (R12) Flags: bit 8 current limiting.
// (R13) Flags: bit 1 reverse rotation.
// (R14) Output terminal item: bit 0 shows first general output.
// (R15) Four deep fault history: latest, previous, third, fourth.
// (R16) Fault codes are hex values, zero means no alarm.
// (R17) Run hours count 0 to 65535, one per hour, saturating.
// (R18) DC bus voltage one count per volt, 500 or 1000 span.
// (R19) Firmware revision 0-99 standard, above 100 non-standard.
// (R20) Link error holds latest code, cleared at power-up.
// (R21) Negative values are two's complement in 16 bits.
// (R22) Each value is sent as four ASCII hex characters.
// ----------------------------------------
`timescale 1ns/100ps
`default_nettype none
`include "dmrb_defs.vh"

module dmrb_bank #(
	parameter [15:0] MODEL_CODE  = 16'h0A5A,
	parameter [15:0] RATED_CODE  = 16'h0064,
	parameter [15:0] FW_REV      = 16'h0001,
	parameter [15:0] BUS_MAX     = 16'd1000,
	parameter [39:0] HOUR_CYCLES = `DMRB_HOUR_CYCLES
) (
	input  wire        clk_sys,
	input  wire        arst_n,
	input  wire [15:0] torque_cur_in,
	input  wire [15:0] out_freq_in,
	input  wire        rot_reverse_in,
	input  wire [15:0] motor_pwr_in,
	input  wire [15:0] out_cur_in,
	input  wire [15:0] out_volt_in,
	input  wire [15:0] dc_bus_in,
	input  wire [15:0] cap_wear_in,
	input  wire [15:0] fan_wear_in,
	input  wire        link_clear,
	input  wire        link_forward_run,
	input  wire        link_reverse_run,
	input  wire [4:0]  link_gen_inputs,
	input  wire        term_clear,
	input  wire        term_forward_run,
	input  wire        term_reverse_run,
	input  wire [4:0]  term_gen_inputs,
	input  wire        param_busy,
	input  wire        link_cmd_valid,
	input  wire        trip,
	input  wire        decel,
	input  wire        accel,
	input  wire        cur_limit,
	input  wire        volt_limit,
	input  wire        torque_limit,
	input  wire        bus_ok,
	input  wire        braking,
	input  wire        shutoff,
	input  wire        dc_braking,
	input  wire        running,
	input  wire        gen_output_one,
	input  wire        fault_new,
	input  wire [15:0] fault_code,
	input  wire        link_err_set,
	input  wire [15:0] link_err_in,
	input  wire        rd_req,
	input  wire [4:0]  rd_sel,
	output reg         rd_ack,
	output reg         rd_hit,
	output reg         rd_dir_valid,
	output reg  [7:0]  rd_dir_char,
	output reg  [31:0] rd_ascii,
	output reg  [15:0] rd_value
);

// ----------------------------------------
// Reset release
// ----------------------------------------
reg rst_s1_r;
reg rst_s2_r;
always @(posedge clk_sys or negedge arst_n) begin
	if (!arst_n) begin
		rst_s1_r <= 1'b0;
		rst_s2_r <= 1'b0;
	end else begin
		rst_s1_r <= 1'b1;
		rst_s2_r <= rst_s1_r;
	end
end
wire rst_n = rst_s2_r;

// ----------------------------------------
// Input synchronisers for terminal pins
// ----------------------------------------
reg [7:0] term_s1_r;
reg [7:0] term_s2_r;
always @(posedge clk_sys or negedge rst_n) begin
	if (!rst_n) begin
		term_s1_r <= 8'h00;
		term_s2_r <= 8'h00;
	end else begin
		term_s1_r <= {term_clear, term_gen_inputs,
			term_reverse_run, term_forward_run};
		term_s2_r <= term_s1_r;
	end
end

// ----------------------------------------
// Fault history and link error
// ----------------------------------------
reg [15:0] fault_r [0:3];
reg [15:0] link_err_r;
integer    i;
always @(posedge clk_sys or negedge rst_n) begin
	if (!rst_n) begin
		for (i = 0; i < 4; i = i + 1)
			fault_r[i] <= `DMRB_NO_ALARM; // [R16]
		link_err_r <= `DMRB_ZERO16; // [R20]
	end else begin
		if (fault_new) begin
			fault_r[0] <= fault_code; // [R15]
			for (i = 1; i < 4; i = i + 1)
				fault_r[i] <= fault_r[i-1]; // [R15]
		end
		if (link_err_set)
			link_err_r <= link_err_in; // [R20]
	end
end

// ----------------------------------------
// Run hours
// ----------------------------------------
reg [39:0] hour_cnt_r;
reg [15:0] hours_r;
always @(posedge clk_sys or negedge rst_n) begin
	if (!rst_n) begin
		hour_cnt_r <= 40'h00_0000_0000;
		hours_r    <= `DMRB_ZERO16;
	end else if (running) begin
		if (hour_cnt_r >= HOUR_CYCLES - 40'h00_0000_0001) begin
			hour_cnt_r <= 40'h00_0000_0000;
			if (hours_r != `DMRB_HOURS_MAX)
				hours_r <= hours_r + 16'h0001; // [R17]
		end else begin
			hour_cnt_r <= hour_cnt_r + 40'h00_0000_0001;
		end
	end
end

// ----------------------------------------
// Composite words
// ----------------------------------------
wire [15:0] run_cmd_w;
wire [15:0] flags_w;
wire [15:0] bus_w;
wire [15:0] fw_w;
wire [15:0] freq_mag_w;

assign run_cmd_w = {link_clear | term_s2_r[7], 8'h00, // [R06]
	link_gen_inputs | term_s2_r[6:2],             // [R07]
	link_reverse_run | term_s2_r[1],              // [R07]
	link_forward_run | term_s2_r[0]};             // [R06]

assign flags_w = {param_busy, 2'b00, link_cmd_valid, trip, // [R08]
	decel, accel,                                  // [R09]
	cur_limit,                                     // [R12]
	volt_limit, torque_limit, bus_ok, braking,     // [R10]
	shutoff, dc_braking,                           // [R11]
	running & rot_reverse_in,                      // [R13]
	running & ~rot_reverse_in};                    // [R11]

assign bus_w = (dc_bus_in > BUS_MAX) ? BUS_MAX : dc_bus_in; // [R18]
assign fw_w  = FW_REV; // [R19]
// Magnitude only; sign goes into the direction character
assign freq_mag_w = out_freq_in[15] ? (~out_freq_in + 16'h0001)
	: out_freq_in; // [R02]

// ----------------------------------------
// Hex to ASCII
// ----------------------------------------
function [7:0] dmrb_hex;
	input [3:0] nib;
	begin
		if (nib < 4'hA)
			dmrb_hex = `DMRB_ASCII_0 + {4'h0, nib};
		else
			dmrb_hex = `DMRB_ASCII_A_10 + {4'h0, nib};
	end
endfunction

// ----------------------------------------
// Item select
// ----------------------------------------
reg [15:0] sel_val;
reg        sel_hit;
always @* begin
	sel_hit = 1'b1;
	case (rd_sel)
	`DMRB_IDX_TORQUE_CUR:  sel_val = torque_cur_in; // [R01] [R21]
	`DMRB_IDX_OUT_FREQ:    sel_val = freq_mag_w;    // [R02]
	`DMRB_IDX_MOTOR_PWR:   sel_val = motor_pwr_in;  // [R04] [R21]
	`DMRB_IDX_OUT_CUR:     sel_val = out_cur_in;    // [R05]
	`DMRB_IDX_OUT_VOLT:    sel_val = out_volt_in;
	`DMRB_IDX_RUN_CMD:     sel_val = run_cmd_w;
	`DMRB_IDX_STATE_FLAGS: sel_val = flags_w;
	`DMRB_IDX_OUT_TERM:    sel_val = {15'h0000, gen_output_one}; // [R14]
	`DMRB_IDX_FAULT_0:     sel_val = fault_r[0]; // [R15]
	`DMRB_IDX_FAULT_1:     sel_val = fault_r[1];
	`DMRB_IDX_FAULT_2:     sel_val = fault_r[2];
	`DMRB_IDX_FAULT_3:     sel_val = fault_r[3];
	`DMRB_IDX_RUN_HOURS:   sel_val = hours_r;
	`DMRB_IDX_DC_BUS:      sel_val = bus_w;
	`DMRB_IDX_MODEL:       sel_val = MODEL_CODE;
	`DMRB_IDX_RATED_PWR:   sel_val = RATED_CODE;
	`DMRB_IDX_FW_REV:      sel_val = fw_w;
	`DMRB_IDX_LINK_ERR:    sel_val = link_err_r;
	`DMRB_IDX_CAP_WEAR:    sel_val = cap_wear_in;
	`DMRB_IDX_FAN_WEAR:    sel_val = fan_wear_in;
	default: begin
		sel_val = `DMRB_ZERO16;
		sel_hit = 1'b0;
	end
	endcase
end

// ----------------------------------------
// Answer registers
// ----------------------------------------
always @(posedge clk_sys or negedge rst_n) begin
	if (!rst_n) begin
		rd_ack       <= 1'b0;
		rd_hit       <= 1'b0;
		rd_dir_valid <= 1'b0;
		rd_dir_char  <= `DMRB_ASCII_SPACE;
		rd_ascii     <= 32'h3030_3030;
		rd_value     <= `DMRB_ZERO16;
	end else begin
		rd_ack <= rd_req;
		if (rd_req) begin
			rd_hit   <= sel_hit;
			rd_value <= sel_val;
			rd_ascii <= {dmrb_hex(sel_val[15:12]), // [R22]
				dmrb_hex(sel_val[11:8]),
				dmrb_hex(sel_val[7:4]),
				dmrb_hex(sel_val[3:0])};
			rd_dir_valid <= (rd_sel == `DMRB_IDX_OUT_FREQ); // [R03]
			rd_dir_char  <= (out_freq_in[15] | (running & rot_reverse_in))
				? `DMRB_ASCII_MINUS : `DMRB_ASCII_SPACE; // [R03]
		end
	end
end

endmodule
`default_nettype wire

//--- verilog/dmrb_defs.vh
// Constants for the drive monitor readout bank
`ifndef DMRB_DEFS_VH
`define DMRB_DEFS_VH

// ----------------------------------------
// Item indices (selector codes)
// ----------------------------------------
`define DMRB_IDX_TORQUE_CUR   5'h08
`define DMRB_IDX_OUT_FREQ     5'h09
`define DMRB_IDX_MOTOR_PWR    5'h0A
`define DMRB_IDX_OUT_CUR      5'h0B
`define DMRB_IDX_OUT_VOLT     5'h0C
`define DMRB_IDX_RUN_CMD      5'h0D
`define DMRB_IDX_STATE_FLAGS  5'h0E
`define DMRB_IDX_OUT_TERM     5'h0F
`define DMRB_IDX_FAULT_0      5'h10
`define DMRB_IDX_FAULT_1      5'h11
`define DMRB_IDX_FAULT_2      5'h12
`define DMRB_IDX_FAULT_3      5'h13
`define DMRB_IDX_RUN_HOURS    5'h14
`define DMRB_IDX_DC_BUS       5'h15
`define DMRB_IDX_MODEL        5'h17
`define DMRB_IDX_RATED_PWR    5'h18
`define DMRB_IDX_FW_REV       5'h19
`define DMRB_IDX_LINK_ERR     5'h1A
`define DMRB_IDX_CAP_WEAR     5'h1B
`define DMRB_IDX_FAN_WEAR     5'h1C

// ----------------------------------------
// Field positions
// ----------------------------------------
`define DMRB_RC_CLEAR    15
`define DMRB_RC_GIN_LSB  2
`define DMRB_RC_REV      1
`define DMRB_RC_FWD      0
`define DMRB_SF_BUSY     15
`define DMRB_SF_LINK_OK  12
`define DMRB_SF_TRIP     11
`define DMRB_SF_DECEL    10
`define DMRB_SF_ACCEL    9
`define DMRB_SF_ILIM     8
`define DMRB_SF_VLIM     7
`define DMRB_SF_TLIM     6
`define DMRB_SF_BUS_OK   5
`define DMRB_SF_BRAKE    4
`define DMRB_SF_SHUTOFF  3
`define DMRB_SF_DCBRAKE  2
`define DMRB_SF_REV      1
`define DMRB_SF_FWD      0

// ----------------------------------------
// Reset values and limits
// ----------------------------------------
`define DMRB_ZERO16      16'h0000
`define DMRB_NO_ALARM    16'h0000
`define DMRB_HOURS_MAX   16'hFFFF
`define DMRB_ASCII_SPACE 8'h20
`define DMRB_ASCII_MINUS 8'h2D
`define DMRB_ASCII_0     8'h30
`define DMRB_ASCII_A_10  8'h37
`define DMRB_HOUR_SEC    3600
`define DMRB_CLK_HZ      100000000
`define DMRB_HOUR_CYCLES 40'h53_D1AC_1000

`endif

//--- testbench/dmrb_chk.sv
// Assertion checker for the drive monitor readout bank
`timescale 1ns/100ps
`default_nettype none
`include "dmrb_defs.vh"
module dmrb_chk (
	input wire logic        clk_sys,
	input wire logic        arst_n,
	input wire logic        rd_req,
	input wire logic [4:0]  rd_sel,
	input wire logic        rd_ack,
	input wire logic        rd_hit,
	input wire logic        rd_dir_valid,
	input wire logic [7:0]  rd_dir_char,
	input wire logic [31:0] rd_ascii,
	input wire logic [15:0] rd_value,
	input wire logic [15:0] out_freq_in,
	input wire logic        rot_reverse_in,
	input wire logic        running
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!arst_n);
	function automatic logic [31:0] hs(input logic [15:0] v);
		integer k;
		for (k = 0; k < 4; k++)
			hs[8*k+:8] = v[4*k+:4] + ((v[4*k+:4] < 4'hA) ? 8'h30 : 8'h37);
	endfunction
	// ----------------
	// Properties
	// ----------------
	property p_ack; rd_req |=> rd_ack; endproperty
	property p_idle; !rd_req |=> !rd_ack; endproperty
	property p_ascii; rd_ack |-> rd_ascii == hs(rd_value); endproperty
	property p_miss;
		rd_req && rd_sel == 5'h00 |=> !rd_hit && rd_value == 16'h0000;
	endproperty
	property p_dirv;
		rd_req |=> rd_dir_valid == $past(rd_sel == `DMRB_IDX_OUT_FREQ);
	endproperty
	property p_dirc;
		rd_req && rd_sel == `DMRB_IDX_OUT_FREQ |=> rd_dir_char ==
			($past(out_freq_in[15] | (running & rot_reverse_in)) ?
			8'h2D : 8'h20);
	endproperty
	property p_freq;
		rd_req && rd_sel == `DMRB_IDX_OUT_FREQ && !out_freq_in[15]
			|=> rd_value == $past(out_freq_in);
	endproperty
	property p_fwd;
		rd_req && rd_sel == `DMRB_IDX_STATE_FLAGS
			|=> rd_value[0] == $past(running & !rot_reverse_in);
	endproperty
	property p_rev;
		rd_req && rd_sel == `DMRB_IDX_STATE_FLAGS
			|=> rd_value[1] == $past(running & rot_reverse_in);
	endproperty
	a_ack: assert property (p_ack) else $error("no ack");
	a_idle: assert property (p_idle) else $error("stray ack");
	a_ascii: assert property (p_ascii) else $error("bad text");
	a_miss: assert property (p_miss) else $error("unmapped hit");
	a_dirv: assert property (p_dirv) else $error("bad dir flag");
	a_dirc: assert property (p_dirc) else $error("bad dir char");
	a_freq: assert property (p_freq) else $error("bad freq");
	a_fwd: assert property (p_fwd) else $error("bad fwd flag");
	a_rev: assert property (p_rev) else $error("bad rev flag");
	c_miss: cover property (rd_req && rd_sel == 5'h00);
	c_rev: cover property (rd_dir_valid && rd_dir_char == 8'h2D);
	c_flag: cover property (rd_ack && rd_value[1]);
endmodule
`default_nettype wire

//--- testbench/dmrb_host.sv
// Host polling model for the readout bank
`timescale 1ns/100ps
`default_nettype none
module dmrb_host (
	input  wire logic       clk_sys,
	output var  logic       rd_req,
	output var  logic [4:0] rd_sel
);
	initial begin
		rd_req = 1'b0;
		rd_sel = 5'h00;
	end
	// One poll, taken on a single edge
	task automatic poll(input logic [4:0] sel);
		@(posedge clk_sys);
		#1;
		rd_req = 1'b1;
		rd_sel = sel;
		@(posedge clk_sys);
		#1;
		rd_req = 1'b0;
		rd_sel = ~sel;
	endtask
endmodule
`default_nettype wire

//--- testbench/dmrb_bank_test.sv
// Self-checking bench for the drive monitor readout bank
`timescale 1ns/100ps
`default_nettype none
`include "dmrb_defs.vh"
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin \
	mismatches++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module dmrb_bank_test;
	logic        clk_sys, arst_n, rd_req, rd_ack, rd_hit, rd_dv;
	logic        gout, fnew, lset, lclr, lfwd, lrev, tclr, tfwd, trev;
	logic [4:0]  rd_sel, lgin, tgin;
	logic [7:0]  rd_dc;
	logic [15:0] st, tq, fq, pw, cu, vo, dc, cw, fw, fc, le, rd_value;
	logic [31:0] rd_ascii;
	integer      mismatches, tests_run, i;
	dmrb_bank #(.HOUR_CYCLES(40'd10)) u_dut (
		.clk_sys(clk_sys), .arst_n(arst_n), .torque_cur_in(tq),
		.out_freq_in(fq), .rot_reverse_in(st[1]), .motor_pwr_in(pw),
		.out_cur_in(cu), .out_volt_in(vo), .dc_bus_in(dc),
		.cap_wear_in(cw), .fan_wear_in(fw), .link_clear(lclr),
		.link_forward_run(lfwd), .link_reverse_run(lrev),
		.link_gen_inputs(lgin), .term_clear(tclr),
		.term_forward_run(tfwd), .term_reverse_run(trev),
		.term_gen_inputs(tgin), .param_busy(st[15]),
		.link_cmd_valid(st[12]), .trip(st[11]), .decel(st[10]),
		.accel(st[9]), .cur_limit(st[8]), .volt_limit(st[7]),
		.torque_limit(st[6]), .bus_ok(st[5]), .braking(st[4]),
		.shutoff(st[3]), .dc_braking(st[2]), .running(st[0] | st[1]),
		.gen_output_one(gout), .fault_new(fnew), .fault_code(fc),
		.link_err_set(lset), .link_err_in(le), .rd_req(rd_req),
		.rd_sel(rd_sel), .rd_ack(rd_ack), .rd_hit(rd_hit),
		.rd_dir_valid(rd_dv), .rd_dir_char(rd_dc),
		.rd_ascii(rd_ascii), .rd_value(rd_value));
	dmrb_host u_host (.clk_sys(clk_sys), .rd_req(rd_req), .rd_sel(rd_sel));
	// ----------------
	// Helpers
	// ----------------
	function automatic logic [31:0] hx(input logic [15:0] v);
		integer k;
		for (k = 0; k < 4; k++)
			hx[8*k+:8] = (v[4*k+:4] > 4'h9) ? 8'h37 + v[4*k+:4] :
				8'h30 + v[4*k+:4];
	endfunction
	task automatic step;
		@(posedge clk_sys);
		#1;
	endtask
	task automatic chkv(input logic [4:0] sel, input logic [15:0] e);
		u_host.poll(sel);
		`CHK("value", e, rd_value)
		`CHK("ascii", hx(e), rd_ascii)
	endtask
	task automatic give_verdict;
		if (mismatches == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// ----------------
	// Scenarios
	// ----------------
	task automatic t_reset;
		for (i = 16; i < 20; i++)
			chkv(i[4:0], 16'h0000);
		chkv(5'h1A, 16'h0000);
		chkv(5'h00, 16'h0000);
		`CHK("hit", 1'b0, rd_hit)
	endtask
	task automatic t_hours;
		chkv(5'h14, 16'h0000);
		st = 16'h0001;
		repeat (30) step;
		st = 16'h0000;
		chkv(5'h14, 16'h0003);
	endtask
	task automatic t_items;
		{tq, pw, cu, vo, dc, cw, fw} = {16'hDEA6, 16'hD8F0, 16'h2710,
			16'h0DAC, 16'h01F4, 16'h03E8, 16'h0005};
		gout = 1'b1;
		step;
		chkv(5'h08, 16'hDEA6);
		chkv(5'h0A, 16'hD8F0);
		chkv(5'h0B, 16'h2710);
		chkv(5'h0C, 16'h0DAC);
		chkv(5'h15, 16'h01F4);
		chkv(5'h1B, 16'h03E8);
		chkv(5'h1C, 16'h0005);
		chkv(5'h0F, 16'h0001);
		chkv(5'h19, 16'h0001);
		dc = 16'h04B0;
		chkv(5'h15, 16'h03E8);
	endtask
	task automatic t_freq;
		fq = 16'h1388;
		for (i = 0; i < 3; i++) begin
			st = (i == 1) ? 16'h0002 : 16'h0001;
			fq = (i == 2) ? 16'hEC78 : 16'h1388;
			chkv(`DMRB_IDX_OUT_FREQ, 16'h1388);
			`CHK("dirv", 1'b1, rd_dv)
			`CHK("dirc", (i > 0) ? 8'h2D : 8'h20, rd_dc)
		end
		st = 16'h0000;
	endtask
	task automatic t_cmd;
		lfwd = 1'b1;
		tgin = 5'b10001;
		repeat (3) step;
		chkv(5'h0D, 16'h0045);
		{tclr, trev, lgin} = {1'b1, 1'b1, 5'b00010};
		repeat (3) step;
		chkv(5'h0D, 16'h804F);
	endtask
	task automatic t_flags;
		for (i = 0; i < 16; i++) begin
			st = 16'h0001 << i;
			chkv(5'h0E, (i == 13 || i == 14) ? 16'h0000 : st);
		end
	endtask
	task automatic t_fault;
		fnew = 1'b1;
		for (i = 0; i < 5; i++) begin
			fc = (i < 3) ? i + 1 : i + 3;
			step;
		end
		fnew = 1'b0;
		{le, lset} = {16'h0002, 1'b1};
		step;
		le = 16'h0005;
		step;
		lset = 1'b0;
		chkv(5'h1A, 16'h0005);
		chkv(5'h10, 16'h0007);
		chkv(5'h11, 16'h0006);
		chkv(5'h12, 16'h0003);
		chkv(5'h13, 16'h0002);
	endtask
	// ----------------
	// Main sequence
	// ----------------
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	initial begin
		repeat (20000) @(posedge clk_sys);
		mismatches++;
		give_verdict;
	end
	initial begin
		{mismatches, tests_run, arst_n} = '0;
		{gout, fnew, lset, lclr, lfwd, lrev, tclr, tfwd, trev} = '0;
		{st, tq, fq, pw, cu, vo, dc, cw, fw, fc, le, lgin, tgin} = '0;
		repeat (10) step;
		arst_n = 1'b1;
		repeat (3) step;
		t_reset;
		t_hours;
		t_items;
		t_freq;
		t_cmd;
		t_flags;
		t_fault;
		give_verdict;
	end
endmodule
bind dmrb_bank dmrb_chk u_chk (.clk_sys(clk_sys), .arst_n(arst_n),
	.rd_req(rd_req), .rd_sel(rd_sel), .rd_ack(rd_ack), .rd_hit(rd_hit),
	.rd_dir_valid(rd_dir_valid), .rd_dir_char(rd_dir_char),
	.rd_ascii(rd_ascii), .rd_value(rd_value), .out_freq_in(out_freq_in),
	.rot_reverse_in(rot_reverse_in), .running(running));
`default_nettype wire
